/* hw/clk_cfg_pkg.sv */
// Package of register map, field layouts and timing for the oscillator and PLL configuration block
// Functional notes
// (R01) Crystal code is a read-write 4-bit field at bits 9:6, reset 0xB.
// (R02) Codes 0-3 are reserved; 4..15 are ascending crystals; 0xB means 6 MHz.
// (R03) Source field bits 5:4, reset 0: main, internal, internal/4, 11 reserved.
// (R04) Software feeding the PLL from internal oscillator picks the divide-by-four source.
// (R05) Internal verify enable at bit 3 runs a timer; oscillator loss raises an interrupt.
// (R06) Main verify enable at bit 2 runs a timer; oscillator loss raises an interrupt.
// (R07) Internal oscillator disable at bit 1: 0 runs it, 1 stops it; resets 0.
// (R08) Main oscillator disable at bit 0: 0 runs it, 1 stops it; resets 0.
// (R09) PLL powered down when power-down is 1; normal when both controls are 0.
// (R10) Translation register loads after reset and reloads when the crystal code changes.
// (R11) Translation fields: output divider 15:14, feedback 13:5, reference divider 4:0.
// (R12) Translation bits 31:16 are reserved; software never changes them.
// (R13) Software clears power-down and output-enable before relying on the PLL clock.
// (R14) PLL power-down control at bit 13 resets to 1.
// (R15) Divider values come from a fixed table indexed by the crystal code.
`default_nettype none

package clk_cfg_pkg;

  // Register byte offsets
  localparam logic [11:0] RUN_CFG_OFS   = 12'h060;
  localparam logic [11:0] XLAT_OFS      = 12'h064;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h068;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h06C;

  // Run-mode clock configuration layout
  localparam int PLL_PD_BIT   = 13;
  localparam int PLL_OE_N_BIT = 12;
  localparam int CRYSTAL_LSB  = 6;
  localparam int OSC_SRC_LSB  = 4;
  localparam int IOSC_VER_BIT = 3;
  localparam int MOSC_VER_BIT = 2;
  localparam int IOSC_DIS_BIT = 1;
  localparam int MOSC_DIS_BIT = 0;

  typedef struct packed {
    logic [17:0] rsv_hi;
    logic        pd;
    logic        oe_n;
    logic [1:0]  rsv_mid;
    logic [3:0]  crystal;
    logic [1:0]  osc_src;
    logic        iosc_ver;
    logic        mosc_ver;
    logic        iosc_dis;
    logic        mosc_dis;
  } run_cfg_t;

  localparam logic [31:0] RUN_CFG_RESET = 32'h0000_32C0;

  // Crystal codes
  localparam logic [3:0] CRYSTAL_RSV_MAX = 4'h3;
  localparam logic [3:0] CRYSTAL_6MHZ    = 4'hB;

  // Oscillator source encodings
  localparam logic [1:0] OSC_MAIN     = 2'h0;
  localparam logic [1:0] OSC_INT      = 2'h1;
  localparam logic [1:0] OSC_INT_DIV4 = 2'h2;
  localparam logic [1:0] OSC_RSV      = 2'h3;

  // PLL translation layout
  typedef struct packed {
    logic [15:0] rsv;
    logic [1:0]  div_out;
    logic [8:0]  fb;
    logic [4:0]  ref_div;
  } xlat_t;

  localparam logic [31:0] XLAT_RESET = 32'h0000_0000;

  typedef struct packed {
    logic power_down;
    logic output_enable_n;
    logic normal;
  } pll_ctrl_t;

  localparam logic [2:0] PLL_CTRL_RESET = 3'h6;

  typedef struct packed {
    logic [1:0] src;
    logic       iosc_dis;
    logic       mosc_dis;
  } osc_ctrl_t;

  localparam logic [3:0] OSC_CTRL_RESET = 4'h0;

  // Interrupt status and mask layout
  localparam int IRQ_W        = 2;
  localparam int IRQ_MOSC_BIT = 0;
  localparam int IRQ_IOSC_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS    = 25;
  localparam int VERIFY_WINDOW_US = 20;
  localparam int VERIFY_CYCLES    = (VERIFY_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam int VERIFY_CNT_W     = $clog2(VERIFY_CYCLES + 1);

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic       HRESP_OKAY  = 1'h0;

endpackage : clk_cfg_pkg

`default_nettype wire

/* hw/crystal_code_lut.sv */
// Crystal code to PLL divider lookup table with registered output
`default_nettype none

module crystal_lut
  import clk_cfg_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] code,
  output xlat_t           xlat_q
);

  logic [8:0] fb_sel;

  // Fixed output and reference dividers; only feedback tracks the crystal
  localparam logic [1:0] LUT_DIV = 2'h1;
  localparam logic [4:0] LUT_REF = 5'h01;

  always_comb begin
    case (code)
      4'h4:    fb_sel = 9'h0DF;
      4'h5:    fb_sel = 9'h0D9;
      4'h6:    fb_sel = 9'h0C8;
      4'h7:    fb_sel = 9'h0C3;
      4'h8:    fb_sel = 9'h0A3;
      4'h9:    fb_sel = 9'h0A0;
      4'hA:    fb_sel = 9'h09C;
      4'hB:    fb_sel = 9'h085;
      4'hC:    fb_sel = 9'h082;
      4'hD:    fb_sel = 9'h06C;
      4'hE:    fb_sel = 9'h064;
      4'hF:    fb_sel = 9'h061;
      default: fb_sel = 9'h000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin // [R15]
    if (!rstn) begin
      xlat_q <= xlat_t'(XLAT_RESET);
    end else begin
      xlat_q <= xlat_t'({16'h0000, LUT_DIV, fb_sel, LUT_REF});
    end
  end

endmodule : crystal_lut

`default_nettype wire

/* hw/osc_verify_timer.sv */
// Oscillator loss watchdog: flags an oscillator that stops ticking while watched
`default_nettype none

module osc_verify_timer
  import clk_cfg_pkg::*;
#(
  parameter int CNT_W   = VERIFY_CNT_W,
  parameter int TIMEOUT = VERIFY_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic osc_tick,
  output logic      fail_ff
);

  logic [CNT_W-1:0] cnt_ff;
  logic             tripped_ff;
  wire              at_limit = (cnt_ff == CNT_W'(TIMEOUT - 1));
  wire              quiet    = enable & ~osc_tick & ~tripped_ff;

  // Reports once per loss; a fresh tick rearms
  always_ff @(posedge core_clk or negedge rstn) begin // [R05] [R06]
    if (!rstn) begin
      cnt_ff     <= '0;
      tripped_ff <= 1'b0;
      fail_ff    <= 1'b0;
    end else begin
      fail_ff <= quiet & at_limit;
      if (!enable || osc_tick) begin
        cnt_ff     <= '0;
        tripped_ff <= 1'b0;
      end else if (quiet) begin
        cnt_ff     <= at_limit ? cnt_ff : cnt_ff + CNT_W'(1);
        tripped_ff <= at_limit;
      end
    end
  end

  a_fail_needs_en: assert property (@(posedge core_clk) disable iff (!rstn) // [R05] [R06]
    fail_ff |-> $past(enable) && !$past(osc_tick))
    else $error("verify failure without enable or despite a tick");

  a_fail_at_limit: assert property (@(posedge core_clk) disable iff (!rstn) // [R06]
    fail_ff |-> $past(cnt_ff) == CNT_W'(TIMEOUT - 1))
    else $error("verify failure before the full quiet window");

endmodule : osc_verify_timer

`default_nettype wire

/* hw/osc_pll_cfg.sv */
// Oscillator and PLL configuration registers behind an AHB-Lite slave
`default_nettype none

module osc_pll_cfg
  import clk_cfg_pkg::*;
#(
  parameter int VERIFY_TIMEOUT = VERIFY_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        main_osc_tick,
  input  wire logic        internal_osc_tick,
  output pll_ctrl_t        pll_ctrl,
  output osc_ctrl_t        osc_ctrl,
  output xlat_t            pll_xlat,
  output logic             irq
);

  typedef enum logic [1:0] {
    XL_WAIT,
    XL_LOAD,
    XL_IDLE
  } xl_state_t;

  // ---------------------------------------------------------------
  // Address phase decode
  // ---------------------------------------------------------------
  wire        addr_ok = hsel & htrans[1] & hready;
  wire        rd_req  = addr_ok & ~hwrite;
  wire        wr_req  = addr_ok & hwrite;
  wire [11:0] ap_ofs  = haddr[11:0];

  // Only whole-word transfers are issued; the size is not checked
  wire        size_unused = ^hsize;

  logic        wr_pend_ff;
  logic [11:0] wr_ofs_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 12'h000;
    end else begin
      wr_pend_ff <= wr_req;
      wr_ofs_ff  <= ap_ofs;
    end
  end

  // ---------------------------------------------------------------
  // Data phase write strobes
  // ---------------------------------------------------------------
  wire      wr_cfg  = wr_pend_ff & (wr_ofs_ff == RUN_CFG_OFS);
  wire      wr_mask = wr_pend_ff & (wr_ofs_ff == IRQ_MASK_OFS);
  run_cfg_t wdata_cfg;
  assign wdata_cfg = run_cfg_t'(hwdata);

  // ---------------------------------------------------------------
  // Run-mode clock configuration
  // ---------------------------------------------------------------
  run_cfg_t cfg_ff;
  run_cfg_t nxt_cfg;

  // Reserved codes are refused so that the table never sees them
  wire crystal_ok   = wdata_cfg.crystal > CRYSTAL_RSV_MAX; // [R02]
  wire src_ok       = wdata_cfg.osc_src != OSC_RSV; // [R03]
  wire crystal_take = wr_cfg & crystal_ok;
  wire src_take     = wr_cfg & src_ok;

  wire crystal_changed = crystal_take & (wdata_cfg.crystal != cfg_ff.crystal); // [R10]

  assign nxt_cfg.rsv_hi   = 18'h0_0000;
  assign nxt_cfg.rsv_mid  = 2'h0;
  assign nxt_cfg.pd       = wr_cfg ? wdata_cfg.pd : cfg_ff.pd; // [R14]
  assign nxt_cfg.oe_n     = wr_cfg ? wdata_cfg.oe_n : cfg_ff.oe_n;
  assign nxt_cfg.crystal  = crystal_take ? wdata_cfg.crystal : cfg_ff.crystal; // [R01]
  assign nxt_cfg.osc_src  = src_take ? wdata_cfg.osc_src : cfg_ff.osc_src; // [R03]
  assign nxt_cfg.iosc_ver = wr_cfg ? wdata_cfg.iosc_ver : cfg_ff.iosc_ver; // [R05]
  assign nxt_cfg.mosc_ver = wr_cfg ? wdata_cfg.mosc_ver : cfg_ff.mosc_ver; // [R06]
  assign nxt_cfg.iosc_dis = wr_cfg ? wdata_cfg.iosc_dis : cfg_ff.iosc_dis; // [R07]
  assign nxt_cfg.mosc_dis = wr_cfg ? wdata_cfg.mosc_dis : cfg_ff.mosc_dis; // [R08]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= run_cfg_t'(RUN_CFG_RESET); // [R01] [R14]
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ---------------------------------------------------------------
  // PLL mode and oscillator controls, registered outputs
  // ---------------------------------------------------------------
  pll_ctrl_t nxt_pll_ctrl;
  osc_ctrl_t nxt_osc_ctrl;

  assign nxt_pll_ctrl.power_down      = nxt_cfg.pd;
  assign nxt_pll_ctrl.output_enable_n = nxt_cfg.oe_n;
  assign nxt_pll_ctrl.normal          = ~nxt_cfg.pd & ~nxt_cfg.oe_n; // [R09]

  assign nxt_osc_ctrl.src      = nxt_cfg.osc_src;
  assign nxt_osc_ctrl.iosc_dis = nxt_cfg.iosc_dis; // [R07]
  assign nxt_osc_ctrl.mosc_dis = nxt_cfg.mosc_dis; // [R08]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pll_ctrl <= pll_ctrl_t'(PLL_CTRL_RESET);
      osc_ctrl <= osc_ctrl_t'(OSC_CTRL_RESET);
    end else begin
      pll_ctrl <= nxt_pll_ctrl;
      osc_ctrl <= nxt_osc_ctrl;
    end
  end

  // ---------------------------------------------------------------
  // Translation register loader
  // ---------------------------------------------------------------
  // Table is fed the next code so it settles in the same edge as the field
  xlat_t     lut_q;
  xl_state_t xl_state_ff;
  xl_state_t nxt_xl_state;

  crystal_lut u_lut (
    .core_clk (core_clk),
    .rstn     (rstn),
    .code     (nxt_cfg.crystal),
    .xlat_q   (lut_q)
  );

  always_comb begin // [R10]
    case (xl_state_ff)
      XL_WAIT: nxt_xl_state = XL_LOAD;
      XL_LOAD: nxt_xl_state = crystal_changed ? XL_LOAD : XL_IDLE;
      XL_IDLE: nxt_xl_state = crystal_changed ? XL_LOAD : XL_IDLE;
      default: nxt_xl_state = XL_WAIT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xl_state_ff <= XL_WAIT;
      pll_xlat    <= xlat_t'(XLAT_RESET);
    end else begin
      xl_state_ff <= nxt_xl_state;
      if (xl_state_ff == XL_LOAD) begin
        pll_xlat <= lut_q; // [R10] [R11]
      end
    end
  end

  // ---------------------------------------------------------------
  // Oscillator verification
  // ---------------------------------------------------------------
  // A deliberately stopped oscillator is not reported as lost
  wire mosc_watch = cfg_ff.mosc_ver & ~cfg_ff.mosc_dis; // [R06]
  wire iosc_watch = cfg_ff.iosc_ver & ~cfg_ff.iosc_dis; // [R05]
  wire mosc_fail;
  wire iosc_fail;

  osc_verify_timer #(
    .CNT_W   ($clog2(VERIFY_TIMEOUT + 1)),
    .TIMEOUT (VERIFY_TIMEOUT)
  ) u_mosc_verify (
    .core_clk (core_clk),
    .rstn     (rstn),
    .enable   (mosc_watch),
    .osc_tick (main_osc_tick),
    .fail_ff  (mosc_fail)
  );

  osc_verify_timer #(
    .CNT_W   ($clog2(VERIFY_TIMEOUT + 1)),
    .TIMEOUT (VERIFY_TIMEOUT)
  ) u_iosc_verify (
    .core_clk (core_clk),
    .rstn     (rstn),
    .enable   (iosc_watch),
    .osc_tick (internal_osc_tick),
    .fail_ff  (iosc_fail)
  );

  // ---------------------------------------------------------------
  // Interrupt status, mask and output
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] stat_ff;
  logic [IRQ_W-1:0] mask_ff;
  logic [IRQ_W-1:0] ev_set;
  logic [IRQ_W-1:0] nxt_stat;
  logic [IRQ_W-1:0] nxt_mask;

  assign ev_set[IRQ_MOSC_BIT] = mosc_fail;
  assign ev_set[IRQ_IOSC_BIT] = iosc_fail;

  // Read clears, but an event in the same cycle survives the clear
  wire stat_rd = rd_req & (ap_ofs == IRQ_STAT_OFS);
  assign nxt_stat = (stat_ff & ~{IRQ_W{stat_rd}}) | ev_set; // [R05] [R06]
  assign nxt_mask = wr_mask ? hwdata[IRQ_W-1:0] : mask_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_ff <= IRQ_RESET;
      mask_ff <= IRQ_RESET;
      irq     <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq     <= |(nxt_stat & nxt_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read data and bus response
  // ---------------------------------------------------------------
  // Configuration reads see a write still in its data phase
  wire        sel_cfg  = ap_ofs == RUN_CFG_OFS;
  wire        sel_xlat = ap_ofs == XLAT_OFS;
  wire        sel_stat = ap_ofs == IRQ_STAT_OFS;
  wire        sel_mask = ap_ofs == IRQ_MASK_OFS;
  wire [31:0] rd_cfg   = nxt_cfg;
  wire [31:0] rd_xlat  = {16'h0000, pll_xlat[15:0]}; // [R11] [R12]
  wire [31:0] rd_stat  = {{(32 - IRQ_W){1'b0}}, stat_ff};
  wire [31:0] rd_mask  = {{(32 - IRQ_W){1'b0}}, nxt_mask};
  wire [31:0] rd_val   = sel_cfg  ? rd_cfg  :
                         sel_xlat ? rd_xlat :
                         sel_stat ? rd_stat :
                         sel_mask ? rd_mask : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hrdata    <= rd_req ? rd_val : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY | (size_unused & 1'b0);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_reset_defaults: assert property ( // [R14]
    $rose(rstn) |-> pll_ctrl.power_down && cfg_ff.crystal == CRYSTAL_6MHZ)
    else $error("power-down or crystal code wrong after reset");

  a_pll_mode: assert property ( // [R09]
    pll_ctrl.normal == (!pll_ctrl.power_down && !pll_ctrl.output_enable_n))
    else $error("PLL mode does not match the power-down and enable bits");

  a_boot_load: assert property ( // [R10]
    $rose(rstn) |-> ##2 (pll_xlat == lut_q && xl_state_ff == XL_IDLE))
    else $error("translation register not loaded after reset");

  a_crystal_reload: assert property ( // [R10]
    crystal_changed ##1 !crystal_changed |=> pll_xlat == lut_q)
    else $error("translation register not refreshed after crystal change");

  a_crystal_no_rsv: assert property ( // [R02]
    cfg_ff.crystal > CRYSTAL_RSV_MAX)
    else $error("crystal field holds a reserved code");

  a_src_no_rsv: assert property ( // [R03]
    wr_cfg && wdata_cfg.osc_src == OSC_RSV |=> $stable(cfg_ff.osc_src))
    else $error("reserved source code was stored");

  a_osc_disable: assert property ( // [R07] [R08]
    wr_cfg |=> osc_ctrl.iosc_dis == $past(hwdata[IOSC_DIS_BIT])
            && osc_ctrl.mosc_dis == $past(hwdata[MOSC_DIS_BIT]))
    else $error("oscillator disable outputs do not follow the write");

  a_xlat_read: assert property ( // [R11] [R12]
    rd_req && sel_xlat && xl_state_ff == XL_IDLE && !crystal_changed
      |=> hrdata == {16'h0000, pll_xlat[15:0]})
    else $error("translation read-back mismatch");

  a_irq_level: assert property ( // [R05]
    irq == |(stat_ff & mask_ff))
    else $error("interrupt output does not match masked status");

endmodule : osc_pll_cfg

`default_nettype wire

/* sim/osc_pll_cfg_test.sv */
// Register-level testbench for the oscillator and PLL configuration block
`default_nettype none

module osc_pll_cfg_test
  import clk_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          TIMEOUT   = 16;
  localparam logic [31:0] CFG_ADDR  = 32'h0000_0060;
  localparam logic [31:0] TRAN_ADDR = 32'h0000_0064;
  localparam logic [31:0] STAT_ADDR = 32'h0000_0068;
  localparam logic [31:0] MASK_ADDR = 32'h0000_006C;
  localparam logic [31:0] HOLE_ADDR = 32'h0000_0070;

  logic        core_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        main_osc_tick;
  logic        internal_osc_tick;
  pll_ctrl_t   pll_ctrl;
  osc_ctrl_t   osc_ctrl;
  xlat_t       pll_xlat;
  logic        irq;
  logic        m_run;
  logic        i_run;
  int          failures;
  int          checks_done;
  logic [8:0]  fb_tab [4:15] = '{9'h0DF, 9'h0D9, 9'h0C8, 9'h0C3, 9'h0A3, 9'h0A0,
                                 9'h09C, 9'h085, 9'h082, 9'h06C, 9'h064, 9'h061};

  assign hready = hreadyout;

  osc_pll_cfg #(.VERIFY_TIMEOUT(TIMEOUT)) dut (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .main_osc_tick(main_osc_tick), .internal_osc_tick(internal_osc_tick),
    .pll_ctrl(pll_ctrl), .osc_ctrl(osc_ctrl), .pll_xlat(pll_xlat), .irq(irq)
  );

  always #12.5 core_clk = ~core_clk;

  // Toggling keeps one pulse per activity; stopping a run flag models a dead oscillator
  always @(posedge core_clk) begin
    main_osc_tick     <= m_run & ~main_osc_tick;
    internal_osc_tick <= i_run & ~internal_osc_tick;
  end

  function automatic logic [31:0] tran_exp(input logic [3:0] c);
    return {16'h0000, 2'h1, fb_tab[c], 5'h01};
  endfunction : tran_exp

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the address phase, then the data phase, each until hready is seen high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask : rd_chk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    main_osc_tick = 1'b0;
    internal_osc_tick = 1'b0;
    m_run = 1'b1;
    i_run = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    settle(3);
    rd_chk(CFG_ADDR, 32'h0000_32C0);
    chk({29'h0, pll_ctrl}, 32'h0000_0006);
    chk({28'h0, osc_ctrl}, 32'h0000_0000);
    rd_chk(TRAN_ADDR, tran_exp(4'hB));
    $display("test reset_values done");
    for (int c = 4; c < 16; c++) begin
      wr(CFG_ADDR, 32'(c) << 6);
      settle(2);
      chk(pll_xlat, tran_exp(4'(c)));
      chk({29'h0, pll_ctrl}, 32'h0000_0001);
      rd_chk(TRAN_ADDR, tran_exp(4'(c)));
    end
    $display("test crystal_codes done");
    wr(CFG_ADDR, 32'h0000_0033);
    settle(2);
    rd_chk(CFG_ADDR, 32'h0000_03C3);
    chk({28'h0, osc_ctrl}, 32'h0000_0003);
    chk(pll_xlat, tran_exp(4'hF));
    for (int s = 0; s < 4; s++) begin
      wr(CFG_ADDR, 32'h0000_2280 | (32'(s) << 4));
      settle(2);
      chk({28'h0, osc_ctrl}, {26'h0, 2'(s == 3 ? 2 : s), 4'h0} >> 2);
      chk({29'h0, pll_ctrl}, 32'h0000_0004);
    end
    rd_chk(CFG_ADDR, 32'h0000_22A0);
    wr(TRAN_ADDR, 32'hFFFF_FFFF);
    rd_chk(TRAN_ADDR, tran_exp(4'hA));
    wr(HOLE_ADDR, 32'hFFFF_FFFF);
    rd_chk(HOLE_ADDR, 32'h0000_0000);
    $display("test refusals done");
    wr(MASK_ADDR, 32'h0000_0000);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    wr(CFG_ADDR, 32'h0000_32C4);
    settle(3 * TIMEOUT);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    m_run = 1'b0;
    settle(3 * TIMEOUT);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(MASK_ADDR, 32'h0000_0001);
    rd_chk(MASK_ADDR, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(STAT_ADDR, 32'h0000_0001);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    m_run = 1'b1;
    wr(CFG_ADDR, 32'h0000_32C8);
    i_run = 1'b0;
    settle(3 * TIMEOUT);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(MASK_ADDR, 32'h0000_0003);
    settle(1);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(STAT_ADDR, 32'h0000_0002);
    settle(1);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(CFG_ADDR, 32'h0000_32C0);
    settle(3 * TIMEOUT);
    rd_chk(STAT_ADDR, 32'h0000_0000);
    $display("test verify_irq done");
    summarize();
  end

  initial begin
    #500000;
    failures++;
    summarize();
  end

endmodule : osc_pll_cfg_test

`default_nettype wire
